/* File: hw/cmq_pkg.sv */
// Package: register map, reset values and arithmetic constants of the coarse mixer / IQ correction
package cmq_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PAIR_AB_AMPLITUDE_FACTOR = 8'h04;
  localparam logic [7:0] OFS_PAIR_CD_AMPLITUDE_FACTOR = 8'h08;
  localparam logic [7:0] OFS_PAIR_AB_SKEW_COEFFICIENT = 8'h0c;
  localparam logic [7:0] OFS_PAIR_CD_SKEW_COEFFICIENT = 8'h10;
  localparam logic [7:0] OFS_CHAN_A_DC_SHIFT = 8'h14;
  localparam logic [7:0] OFS_CHAN_B_DC_SHIFT = 8'h18;
  localparam logic [7:0] OFS_CHAN_C_DC_SHIFT = 8'h1c;
  localparam logic [7:0] OFS_CHAN_D_DC_SHIFT = 8'h20;
  localparam logic [7:0] OFS_TIMING_TRIM = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CTRL_CMIX_LSB = 0;
  localparam int CTRL_MIX_GAIN_BIT = 4;
  localparam int CTRL_FINE_EN_BIT = 5;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_CMIX = 4'h0;
  localparam logic RST_MIX_GAIN = 1'b0;
  localparam logic [10:0] RST_AMPLITUDE = 11'h400;
  localparam logic [11:0] RST_SKEW = 12'h000;
  localparam logic [12:0] RST_DC_SHIFT = 13'h0000;
  localparam logic [7:0] RST_TRIM = 8'h00;
  // ****************************************
  // Arithmetic
  // ****************************************
  localparam int AMP_FRAC = 10;
  localparam int SKEW_FRAC = 12;
  localparam int TRIG_FRAC = 15;
  localparam logic signed [15:0] TRIG_ONE = 16'sh7fff;
  localparam logic signed [15:0] TRIG_HALF_ROOT2 = 16'sh5a82;
  localparam logic signed [35:0] SAMPLE_MAX = 36'sh0_0000_7fff;
  localparam logic signed [35:0] SAMPLE_MIN = -36'sh0_0000_8000;
  // ****************************************
  // Coarse selector bits
  // ****************************************
  localparam int CMIX_NEG_QUARTER = 0;
  localparam int CMIX_HALF = 1;
  localparam int CMIX_QUARTER = 2;
  localparam int CMIX_EIGHTH = 3;
endpackage : cmq_pkg

/* File: hw/cmq_mixer_qmc.sv */
// Coarse complex mixer and quadrature correction datapath with an AHB-Lite register slave
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - fs/2, fs/4, -fs/4 use only negate and swap, never the multiplier or its gain.
// - fs/2 keeps samples 1 and 3 of four, negates samples 2 and 4.
// - +fs/4 gives I: +I,-Q,-I,+Q and Q: +Q,+I,-Q,-I.
// - -fs/4 gives I: +I,+Q,-I,-Q and Q: +Q,-I,-Q,+I.
// - fs/8 uses the multiplier with fixed eighth-rate terms, combinable with others.
// - Codes 1010, 1100, 1110 give -3fs/8, +3fs/8 and -fs/8.
// - With the multiplier in use, a cleared gain bit halves its output.
// - Only bypass and fs/2 keep real channels separate; others mix pairs complex.
// - Each pair has an 11-bit unsigned gain, ten fraction bits, reset to unity.
// - Each pair has a 12-bit signed phase coefficient from -0.5 to under 0.5.
// - Phase correction adds Q times coefficient into I.
// - Each channel has a 13-bit signed DC offset, -4096 to 4095.
// - Offset LSB aligns with sample LSB.
// - Each channel has an 8-bit timing trim shifting its samples.
// - Pairs A/B and C/D have independent mixing paths.
module cmq_mixer_qmc #(
  parameter int TRIM_DEPTH = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Sample input
  input wire logic IN_VALID,
  input wire logic [15:0] IN_A,
  input wire logic [15:0] IN_B,
  input wire logic [15:0] IN_C,
  input wire logic [15:0] IN_D,
  // Fine oscillator stage terms
  input wire logic [15:0] FINE_COS_AB,
  input wire logic [15:0] FINE_SIN_AB,
  input wire logic [15:0] FINE_COS_CD,
  input wire logic [15:0] FINE_SIN_CD,
  // Sample output
  output logic OUT_VALID,
  output logic [15:0] OUT_A,
  output logic [15:0] OUT_B,
  output logic [15:0] OUT_C,
  output logic [15:0] OUT_D
);

  if (TRIM_DEPTH < 1 || TRIM_DEPTH > 255) begin : g_bad_depth
    $error("TRIM_DEPTH must lie in 1..255");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0] cmix;
    logic mix_gain;
    logic fine_en;
    logic [1:0][10:0] amp;
    logic [1:0][11:0] skew;
    logic [3:0][12:0] dc;
    logic [3:0][7:0] trim;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
    logic [2:0] k;
    logic v1;
    logic [3:0][15:0] s1;
    logic v2;
    logic [3:0][15:0] s2;
    logic [3:0] clip;
    logic [TRIM_DEPTH-1:0][3:0][15:0] dl;
    logic vo;
    logic [3:0][15:0] dout;
  } cmq_state_s;

  cmq_state_s st_q;
  cmq_state_s st_d;
  logic [3:0][15:0] in_w;
  logic [1:0][15:0] fc_w;
  logic [1:0][15:0] fs_w;

  assign in_w = {IN_D, IN_C, IN_B, IN_A};
  assign fc_w = {FINE_COS_CD, FINE_COS_AB};
  assign fs_w = {FINE_SIN_CD, FINE_SIN_AB};

  // ****************************************
  // Arithmetic helpers
  // ****************************************
  function automatic logic [15:0] cmq_sat(input logic signed [35:0] v);
    if (v > cmq_pkg::SAMPLE_MAX) begin
      return 16'h7fff;
    end else if (v < cmq_pkg::SAMPLE_MIN) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction : cmq_sat

  function automatic logic [15:0] cmq_neg(input logic [15:0] x);
    return cmq_sat(-36'($signed(x)));
  endfunction : cmq_neg

  // Eighth-rate cosine; sine is cosine two steps back
  function automatic logic [15:0] cmq_cos8(input logic [2:0] k);
    logic [15:0] r;
    r = 16'h0000;
    unique case (k)
      3'd0: r = cmq_pkg::TRIG_ONE;
      3'd1, 3'd7: r = cmq_pkg::TRIG_HALF_ROOT2;
      3'd2, 3'd6: r = 16'h0000;
      3'd3, 3'd5: r = -cmq_pkg::TRIG_HALF_ROOT2;
      3'd4: r = -cmq_pkg::TRIG_ONE;
    endcase
    return r;
  endfunction : cmq_cos8

  // Complex multiply, halved when the gain bit is clear
  function automatic logic [31:0] cmq_cmul(input logic [15:0] i, input logic [15:0] q,
                                           input logic [15:0] c, input logic [15:0] s,
                                           input logic g);
    logic signed [35:0] ri;
    logic signed [35:0] rq;
    ri = 36'($signed(i)) * 36'($signed(c)) - 36'($signed(q)) * 36'($signed(s));
    rq = 36'($signed(i)) * 36'($signed(s)) + 36'($signed(q)) * 36'($signed(c));
    ri = ri >>> (g ? cmq_pkg::TRIG_FRAC : cmq_pkg::TRIG_FRAC + 1);
    rq = rq >>> (g ? cmq_pkg::TRIG_FRAC : cmq_pkg::TRIG_FRAC + 1);
    return {cmq_sat(ri), cmq_sat(rq)};
  endfunction : cmq_cmul

  // Quarter-rate step by negate and swap
  function automatic logic [31:0] cmq_quarter(input logic [15:0] i, input logic [15:0] q,
                                              input logic [1:0] m);
    logic [31:0] r;
    r = {i, q};
    unique case (m)
      2'd0: r = {i, q};
      2'd1: r = {cmq_neg(q), i};
      2'd2: r = {cmq_neg(i), cmq_neg(q)};
      2'd3: r = {q, cmq_neg(i)};
    endcase
    return r;
  endfunction : cmq_quarter

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] mi;
    logic [15:0] mq;
    logic [31:0] pr;
    logic signed [35:0] ci;
    logic signed [35:0] cq;
    logic signed [35:0] amp_s;
    logic [7:0] ra;
    int t;
    mi = 16'h0000;
    mq = 16'h0000;
    pr = 32'h0000_0000;
    ci = 36'sh0;
    cq = 36'sh0;
    amp_s = 36'sh0;
    ra = 8'h00;
    t = 0;
    st_d = st_q;
    // Bus write data phase
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        cmq_pkg::OFS_CTRL: begin
          st_d.cmix = HWDATA[cmq_pkg::CTRL_CMIX_LSB +: 4];
          st_d.mix_gain = HWDATA[cmq_pkg::CTRL_MIX_GAIN_BIT];
          st_d.fine_en = HWDATA[cmq_pkg::CTRL_FINE_EN_BIT];
        end
        cmq_pkg::OFS_PAIR_AB_AMPLITUDE_FACTOR: st_d.amp[0] = HWDATA[10:0];
        cmq_pkg::OFS_PAIR_CD_AMPLITUDE_FACTOR: st_d.amp[1] = HWDATA[10:0];
        cmq_pkg::OFS_PAIR_AB_SKEW_COEFFICIENT: st_d.skew[0] = HWDATA[11:0];
        cmq_pkg::OFS_PAIR_CD_SKEW_COEFFICIENT: st_d.skew[1] = HWDATA[11:0];
        cmq_pkg::OFS_CHAN_A_DC_SHIFT: st_d.dc[0] = HWDATA[12:0];
        cmq_pkg::OFS_CHAN_B_DC_SHIFT: st_d.dc[1] = HWDATA[12:0];
        cmq_pkg::OFS_CHAN_C_DC_SHIFT: st_d.dc[2] = HWDATA[12:0];
        cmq_pkg::OFS_CHAN_D_DC_SHIFT: st_d.dc[3] = HWDATA[12:0];
        cmq_pkg::OFS_TIMING_TRIM: st_d.trim = HWDATA;
        default: ;
      endcase
    end
    // Bus address phase; reads see a write completing in the same cycle
    st_d.wr_pend = HSEL && HREADY && HTRANS[1] && HWRITE;
    st_d.wr_addr = {HADDR[7:2], 2'b00};
    st_d.rdy = 1'b1;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      ra = {HADDR[7:2], 2'b00};
      st_d.rdata = 32'h0000_0000;
      unique case (ra)
        cmq_pkg::OFS_CTRL: st_d.rdata = 32'({st_d.fine_en, st_d.mix_gain, st_d.cmix});
        cmq_pkg::OFS_PAIR_AB_AMPLITUDE_FACTOR: st_d.rdata = 32'(st_d.amp[0]);
        cmq_pkg::OFS_PAIR_CD_AMPLITUDE_FACTOR: st_d.rdata = 32'(st_d.amp[1]);
        cmq_pkg::OFS_PAIR_AB_SKEW_COEFFICIENT: st_d.rdata = 32'(st_d.skew[0]);
        cmq_pkg::OFS_PAIR_CD_SKEW_COEFFICIENT: st_d.rdata = 32'(st_d.skew[1]);
        cmq_pkg::OFS_CHAN_A_DC_SHIFT: st_d.rdata = 32'(st_d.dc[0]);
        cmq_pkg::OFS_CHAN_B_DC_SHIFT: st_d.rdata = 32'(st_d.dc[1]);
        cmq_pkg::OFS_CHAN_C_DC_SHIFT: st_d.rdata = 32'(st_d.dc[2]);
        cmq_pkg::OFS_CHAN_D_DC_SHIFT: st_d.rdata = 32'(st_d.dc[3]);
        cmq_pkg::OFS_TIMING_TRIM: st_d.rdata = st_d.trim;
        cmq_pkg::OFS_STATUS: st_d.rdata = 32'({st_q.clip, 1'b0, st_q.k});
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    // Mixing stage, one path per pair
    st_d.v1 = IN_VALID;
    if (IN_VALID) begin
      st_d.k = st_q.k + 3'd1;
      for (int p = 0; p < 2; p++) begin
        mi = in_w[2*p];
        mq = in_w[2*p+1];
        if (st_q.cmix[cmq_pkg::CMIX_EIGHTH]) begin
          pr = cmq_cmul(mi, mq, cmq_cos8(st_q.k), cmq_cos8(st_q.k + 3'd6), st_q.mix_gain);
          mi = pr[31:16];
          mq = pr[15:0];
        end else if (st_q.fine_en) begin
          pr = cmq_cmul(mi, mq, fc_w[p], fs_w[p], st_q.mix_gain);
          mi = pr[31:16];
          mq = pr[15:0];
        end
        if (st_q.cmix[cmq_pkg::CMIX_QUARTER]) begin
          pr = cmq_quarter(mi, mq, st_q.k[1:0]);
          mi = pr[31:16];
          mq = pr[15:0];
        end
        if (st_q.cmix[cmq_pkg::CMIX_HALF] && st_q.k[0]) begin
          mi = cmq_neg(mi);
          mq = cmq_neg(mq);
        end
        if (st_q.cmix[cmq_pkg::CMIX_NEG_QUARTER]) begin
          pr = cmq_quarter(mi, mq, 2'd0 - st_q.k[1:0]);
          mi = pr[31:16];
          mq = pr[15:0];
        end
        st_d.s1[2*p] = mi;
        st_d.s1[2*p+1] = mq;
      end
    end
    // Correction stage: gain, phase, offset with saturation
    st_d.v2 = st_q.v1;
    if (st_q.v1) begin
      for (int p = 0; p < 2; p++) begin
        amp_s = 36'($signed({1'b0, st_q.amp[p]}));
        ci = 36'($signed(st_q.s1[2*p])) * amp_s
             + ((36'($signed(st_q.s1[2*p+1])) * 36'($signed(st_q.skew[p])))
                >>> (cmq_pkg::SKEW_FRAC - cmq_pkg::AMP_FRAC));
        cq = 36'($signed(st_q.s1[2*p+1])) * amp_s;
        ci = (ci >>> cmq_pkg::AMP_FRAC) + 36'($signed(st_q.dc[2*p]));
        cq = (cq >>> cmq_pkg::AMP_FRAC) + 36'($signed(st_q.dc[2*p+1]));
        st_d.s2[2*p] = cmq_sat(ci);
        st_d.s2[2*p+1] = cmq_sat(cq);
        st_d.clip[2*p] = (ci > cmq_pkg::SAMPLE_MAX) || (ci < cmq_pkg::SAMPLE_MIN);
        st_d.clip[2*p+1] = (cq > cmq_pkg::SAMPLE_MAX) || (cq < cmq_pkg::SAMPLE_MIN);
      end
    end
    // Timing trim: whole-sample delay, capped at the line depth
    st_d.vo = st_q.v2;
    if (st_q.v2) begin
      st_d.dl[0] = st_q.s2;
      for (int j = 1; j < TRIM_DEPTH; j++) begin
        st_d.dl[j] = st_q.dl[j-1];
      end
      for (int c = 0; c < 4; c++) begin
        t = (int'(st_q.trim[c]) > TRIM_DEPTH) ? TRIM_DEPTH : int'(st_q.trim[c]);
        st_d.dout[c] = (t == 0) ? st_q.s2[c] : st_q.dl[t-1][c];
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= '0;
      st_q.rdy <= 1'b1;
      st_q.cmix <= cmq_pkg::RST_CMIX;
      st_q.mix_gain <= cmq_pkg::RST_MIX_GAIN;
      st_q.amp <= {2{cmq_pkg::RST_AMPLITUDE}};
      st_q.skew <= {2{cmq_pkg::RST_SKEW}};
      st_q.dc <= {4{cmq_pkg::RST_DC_SHIFT}};
      st_q.trim <= {4{cmq_pkg::RST_TRIM}};
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign HRDATA = st_q.rdata;
  assign HREADYOUT = st_q.rdy;
  assign HRESP = 1'b0;
  assign OUT_VALID = st_q.vo;
  assign OUT_A = st_q.dout[0];
  assign OUT_B = st_q.dout[1];
  assign OUT_C = st_q.dout[2];
  assign OUT_D = st_q.dout[3];

  // ****************************************
  // Checks
  // ****************************************
  property p_bypass;
    @(posedge CLK) disable iff (RST)
      (IN_VALID && st_q.cmix == 4'h0 && !st_q.fine_en) |=> (st_q.s1[0] == $past(IN_A))
      && (st_q.s1[1] == $past(IN_B));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered a sample");
  property p_half;
    @(posedge CLK) disable iff (RST)
      (IN_VALID && st_q.cmix == 4'h2 && st_q.k[0] && IN_C != 16'h8000 && !st_q.fine_en)
      |=> st_q.s1[2] == 16'(-$signed($past(IN_C)));
  endproperty
  a_half: assert property (p_half) else $error("fs/2 did not negate");
  property p_quarter;
    @(posedge CLK) disable iff (RST)
      (IN_VALID && {st_q.fine_en, st_q.cmix} == 5'h04 && st_q.k[1:0] == 2'd1 && IN_B != 16'h8000)
      |=> (st_q.s1[0] == 16'(-$signed($past(IN_B)))) && (st_q.s1[1] == $past(IN_A));
  endproperty
  a_quarter: assert property (p_quarter) else $error("+fs/4 step wrong");
  property p_neg_quarter;
    @(posedge CLK) disable iff (RST)
      (IN_VALID && {st_q.fine_en, st_q.cmix} == 5'h01 && st_q.k[1:0] == 2'd1 && IN_A != 16'h8000)
      |=> (st_q.s1[0] == $past(IN_B)) && (st_q.s1[1] == 16'(-$signed($past(IN_A))));
  endproperty
  a_neg_quarter: assert property (p_neg_quarter) else $error("-fs/4 step wrong");
  property p_eighth_gain;
    @(posedge CLK) disable iff (RST)
      (IN_VALID && st_q.cmix == 4'h8 && st_q.k == 3'd0 && !st_q.mix_gain)
      |=> st_q.s1[0] == 16'((36'($signed($past(IN_A))) * 36'sd32767) >>> 16);
  endproperty
  a_eighth_gain: assert property (p_eighth_gain) else $error("fs/8 half gain wrong");

  property p_skew;
    @(posedge CLK) disable iff (RST)
      (st_q.v1 && st_q.amp[0] == 11'h400 && st_q.dc[0] == 13'h0000)
      |=> st_q.s2[0] == cmq_sat(36'($signed($past(st_q.s1[0])))
          + ((36'($signed($past(st_q.s1[1]))) * 36'($signed($past(st_q.skew[0])))) >>> 12));
  endproperty
  a_skew: assert property (p_skew) else $error("phase correction wrong");

  property p_offset;
    @(posedge CLK) disable iff (RST)
      (st_q.v1 && st_q.amp[1] == 11'h400)
      |=> st_q.s2[3] == cmq_sat(36'($signed($past(st_q.s1[3])))
          + 36'($signed($past(st_q.dc[3]))));
  endproperty
  a_offset: assert property (p_offset) else $error("offset add wrong");

  property p_trim_zero;
    @(posedge CLK) disable iff (RST)
      (st_q.v2 && st_q.trim[1] == 8'h00) |=> OUT_VALID && OUT_B == $past(st_q.s2[1]);
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("zero trim delayed data");

endmodule : cmq_mixer_qmc
`default_nettype wire

/* File: verif/cmq_sample_src.sv */
// Upstream sample source model feeding the coarse mixer and correction datapath
`timescale 1ns/1ps
`default_nettype none
module cmq_sample_src #(
  parameter logic [15:0] FINE_COS = 16'h5a82,
  parameter logic [15:0] FINE_SIN = 16'h5a82
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench request
  input wire logic send,
  input wire logic [15:0] s [4],
  // Datapath side
  output logic in_valid,
  output logic [15:0] smp [4],
  output logic [15:0] fine_cos,
  output logic [15:0] fine_sin
);
  assign fine_cos = FINE_COS;
  assign fine_sin = FINE_SIN;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_valid <= 1'b0;
      for (int n = 0; n < 4; n++) smp[n] <= 16'h0000;
    end else begin
      in_valid <= send;
      // Idle lines toggle so a stale sample is never mistaken for a new one
      for (int n = 0; n < 4; n++) smp[n] <= send ? s[n] : ~smp[n];
    end
  end
endmodule : cmq_sample_src
`default_nettype wire

/* File: verif/test_coarse_mixer_iq_correction.sv */
// Testbench: coarse mixer and IQ correction datapath against a sample-level model
`timescale 1ns/1ps
`default_nettype none
module test_coarse_mixer_iq_correction;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam int DEPTH = 4;
  localparam logic [15:0] FTERM = 16'h5a82;
  typedef struct packed {
    logic [5:0] ctl;
    logic [15:0] base;
  } cmq_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic send = 1'b0;
  logic [15:0] s [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic in_valid;
  logic [15:0] in_s [4];
  logic [15:0] fc;
  logic [15:0] fs;
  logic out_valid;
  logic [15:0] out_s [4];
  logic [31:0] rd;
  int err_total = 0;
  int samples_checked = 0;
  int k_cnt;
  logic [5:0] ctrl;
  int amp [2];
  int skew [2];
  int dc [4];
  int trim [4];
  int c8 [8] = '{32767, 23170, 0, -23170, -32767, -23170, 0, 23170};
  logic [15:0] hist [4][$];
  logic [15:0] expq [4][$];
  logic [31:0] wv [8] = '{32'hfffff7ff, 32'h00000200, 32'h000007ff, 32'hfffff800,
    32'h00000fff, 32'h00001000, 32'h00000005, 32'hffffffff};
  logic [31:0] mk [8] = '{32'h7ff, 32'h7ff, 32'hfff, 32'hfff, 32'h1fff, 32'h1fff, 32'h1fff,
    32'h1fff};
  cmq_row_s rows [16] = '{'{6'h00, 16'hf448}, '{6'h01, 16'h0bb8}, '{6'h02, 16'hf830},
    '{6'h04, 16'h07d0}, '{6'h14, 16'hfc18}, '{6'h08, 16'h0fa0}, '{6'h18, 16'hf060},
    '{6'h0a, 16'h0320}, '{6'h0c, 16'hfce0}, '{6'h0e, 16'h0640}, '{6'h20, 16'hf9c0},
    '{6'h30, 16'h0960}, '{6'h28, 16'hf6a0}, '{6'h03, 16'h0190}, '{6'h07, 16'hfe70},
    '{6'h0b, 16'h0c80}};

  always #20 clk = ~clk;

  // ****************************************
  // Devices
  // ****************************************
  cmq_sample_src #(.FINE_COS(FTERM), .FINE_SIN(FTERM)) cmq_sample_src_i (
    .clk(clk), .rst(rst), .send(send), .s(s), .in_valid(in_valid), .smp(in_s),
    .fine_cos(fc), .fine_sin(fs));
  cmq_mixer_qmc #(.TRIM_DEPTH(DEPTH)) cmq_mixer_qmc_i (
    .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .IN_VALID(in_valid), .IN_A(in_s[0]),
    .IN_B(in_s[1]), .IN_C(in_s[2]), .IN_D(in_s[3]), .FINE_COS_AB(fc), .FINE_SIN_AB(fs),
    .FINE_COS_CD(fc), .FINE_SIN_CD(fs), .OUT_VALID(out_valid), .OUT_A(out_s[0]),
    .OUT_B(out_s[1]), .OUT_C(out_s[2]), .OUT_D(out_s[3]));

  // ****************************************
  // Tasks
  // ****************************************
  function automatic int sat(input longint v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : int'(v));
  endfunction : sat

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_smp(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_smp

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk_reg("hresp", 32'h0, {31'h0, hresp});
    if (w) begin
      case (a)
        cmq_pkg::OFS_CTRL: ctrl = d[5:0];
        cmq_pkg::OFS_PAIR_AB_AMPLITUDE_FACTOR: amp[0] = int'(d[10:0]);
        cmq_pkg::OFS_PAIR_CD_AMPLITUDE_FACTOR: amp[1] = int'(d[10:0]);
        cmq_pkg::OFS_PAIR_AB_SKEW_COEFFICIENT: skew[0] = int'($signed(d[11:0]));
        cmq_pkg::OFS_PAIR_CD_SKEW_COEFFICIENT: skew[1] = int'($signed(d[11:0]));
        cmq_pkg::OFS_CHAN_A_DC_SHIFT: dc[0] = int'($signed(d[12:0]));
        cmq_pkg::OFS_CHAN_B_DC_SHIFT: dc[1] = int'($signed(d[12:0]));
        cmq_pkg::OFS_CHAN_C_DC_SHIFT: dc[2] = int'($signed(d[12:0]));
        cmq_pkg::OFS_CHAN_D_DC_SHIFT: dc[3] = int'($signed(d[12:0]));
        cmq_pkg::OFS_TIMING_TRIM: foreach (trim[c]) trim[c] = int'(d[8 * c +: 8]);
        default: ;
      endcase
    end
  endtask : bus

  task automatic clear_model();
    ctrl = 6'h00;
    amp = '{1024, 1024};
    skew = '{0, 0};
    dc = '{0, 0, 0, 0};
    trim = '{0, 0, 0, 0};
    k_cnt = 0;
    foreach (hist[c]) begin
      expq[c].delete();
      hist[c].delete();
      repeat (DEPTH + 1) hist[c].push_front(16'h0000);
    end
  endtask : clear_model

  task automatic predict(input int v[4]);
    int i, q, t, c, sn, j, d;
    longint m;
    int r[4];
    j = k_cnt % 4;
    for (int p = 0; p < 2; p++) begin
      i = v[2 * p];
      q = v[2 * p + 1];
      c = ctrl[3] ? c8[k_cnt % 8] : int'($signed(FTERM));
      sn = ctrl[3] ? c8[(k_cnt + 6) % 8] : int'($signed(FTERM));
      if (ctrl[3] || ctrl[5]) begin
        t = sat((longint'(i) * c - longint'(q) * sn) >>> (ctrl[4] ? 15 : 16));
        q = sat((longint'(i) * sn + longint'(q) * c) >>> (ctrl[4] ? 15 : 16));
        i = t;
      end
      // Each quarter-rate stage is a rotation by a multiple of 90 degrees
      repeat ((int'(ctrl[2]) * j + int'(ctrl[1]) * 2 * j + int'(ctrl[0]) * 3 * j) % 4) begin
        t = i;
        i = sat(-q);
        q = t;
      end
      m = (longint'(i) * amp[p] + ((longint'(q) * skew[p]) >>> 2)) >>> 10;
      r[2 * p] = sat(m + dc[2 * p]);
      r[2 * p + 1] = sat(((longint'(q) * amp[p]) >>> 10) + dc[2 * p + 1]);
    end
    foreach (r[p]) begin
      d = trim[p] > DEPTH ? DEPTH : trim[p];
      hist[p].push_front(16'(r[p]));
      hist[p].pop_back();
      expq[p].push_back(hist[p][d]);
    end
    k_cnt++;
  endtask : predict

  task automatic burst(input int base, input logic gap, input int num);
    int v[4];
    for (int n = 0; n < num; n++) begin
      foreach (v[c]) v[c] = int'($signed(16'(base + n * 611 - c * 1234)));
      @(posedge clk);
      send <= 1'b1;
      foreach (s[c]) s[c] <= 16'(v[c]);
      predict(v);
      if (gap) begin
        @(posedge clk);
        send <= 1'b0;
      end
    end
    @(posedge clk);
    send <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : burst

  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Output monitor and sequence
  // ****************************************
  always @(negedge clk) begin
    logic [15:0] ev;
    if (out_valid === 1'b1) begin
      for (int p = 0; p < 4; p++) begin
        ev = (expq[p].size() > 0) ? expq[p].pop_front() : 16'hxxxx;
        chk_smp($sformatf("out %0d", p), ev, out_s[p]);
      end
    end
  end

  initial begin
    #800000;
    err_total++;
    test_done();
  end

  initial begin
    clear_model();
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[r]) begin
      bus(1'b1, cmq_pkg::OFS_CTRL, {26'h0, rows[r].ctl}, rd);
      burst(int'($signed(rows[r].base)), 1'(r % 2), 8);
    end
    bus(1'b1, cmq_pkg::OFS_CTRL, 32'h0, rd);
    for (int n = 0; n < 8; n++) begin
      bus(1'b1, 8'(4 + 4 * n), wv[n], rd);
      bus(1'b0, 8'(4 + 4 * n), 32'h0, rd);
      chk_reg($sformatf("reg %0d", n), wv[n] & mk[n], rd);
    end
    burst(32'sh7000, 1'b0, 8);
    burst(-32'sh7000, 1'b1, 8);
    // Unity gain with live skew and live offsets on B, C and D (channel A offset cleared), so the stage checks see non-zero terms
    bus(1'b1, cmq_pkg::OFS_PAIR_AB_AMPLITUDE_FACTOR, 32'h400, rd);
    bus(1'b1, cmq_pkg::OFS_PAIR_CD_AMPLITUDE_FACTOR, 32'h400, rd);
    bus(1'b1, cmq_pkg::OFS_CHAN_A_DC_SHIFT, 32'h0, rd);
    burst(32'sh7000, 1'b0, 8);
    bus(1'b1, cmq_pkg::OFS_TIMING_TRIM, 32'h09000103, rd);
    burst(1500, 1'b1, 11);
    bus(1'b0, cmq_pkg::OFS_STATUS, 32'h0, rd);
    chk_reg("status k", 32'(k_cnt % 8), rd & 32'h7);
    bus(1'b1, 8'h3c, 32'hffffffff, rd);
    bus(1'b0, 8'h2c, 32'h0, rd);
    chk_reg("unmapped", 32'h0, rd);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    clear_model();
    foreach (out_s[p]) chk_smp("out after reset", 16'h0000, out_s[p]);
    chk_reg("valid after reset", 32'h0, {31'h0, out_valid});
    for (int a = 0; a <= 40; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, rd);
      chk_reg($sformatf("reset %0d", a), (a == 4 || a == 8) ? 32'h400 : 32'h0, rd);
    end
    burst(-700, 1'b0, 8);
    repeat (8) @(posedge clk);
    chk_reg("pending", 32'h0, 32'(expq[0].size()));
    test_done();
  end
endmodule : test_coarse_mixer_iq_correction
`default_nettype wire
